// ---- rtl/smc_defs.svh ----
// Purpose: constants of the mode and i2c control register pair
// Assumes: mclk at 125 MHz
// Notes:   offsets, field positions, reset values and timing counts
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define SMC_OFF_MODE      8'h04
`define SMC_OFF_I2C       8'h05
`define SMC_OFF_CRC_LO    8'h0a
`define SMC_OFF_CRC_HI    8'h0b

// -----------------------------------------------------------------
// reset values and writable bits
// -----------------------------------------------------------------
`define SMC_MODE_RST      8'h80
`define SMC_I2C_RST       8'h00
`define SMC_MODE_WMASK    8'haf
`define SMC_I2C_WMASK     8'h1f

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define SMC_B_FAILSAFE    7
`define SMC_B_CRC_CLR     5
`define SMC_B_LEG_SRC     3
`define SMC_B_LEG         2
`define SMC_B_LF_SRC      1
`define SMC_B_LF          0
`define SMC_B_DLY_HI      4
`define SMC_B_DLY_LO      3
`define SMC_B_WBLK        2
`define SMC_B_SPEEDUP     1
`define SMC_B_WDIS        0

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define SMC_CLK_PERIOD_NS   8
`define SMC_SDA_DLY_BASE_NS 240
`define SMC_SDA_DLY_STEP_NS 40
`define SMC_WDOG_LONG_MS    1000
`define SMC_WDOG_SHORT_MS   50
`define SMC_WDOG_LONG_CYC  (`SMC_WDOG_LONG_MS * 1000000 / `SMC_CLK_PERIOD_NS)
`define SMC_WDOG_SHORT_CYC (`SMC_WDOG_SHORT_MS * 1000000 / `SMC_CLK_PERIOD_NS)
`define SMC_CLR_HALF_NS     5000
`define SMC_CLR_HALF_CYC   (`SMC_CLR_HALF_NS / `SMC_CLK_PERIOD_NS)
`define SMC_CLR_PULSES      9
`define SMC_DEV_ADDR        7'h3a

`endif

// ---- rtl/smc_pkg.sv ----
// Purpose: types of the mode and i2c control register pair
// Assumes: nothing
// Notes:   state enums only
`default_nettype none
package smc_pkg;
   typedef enum logic [2:0] {
      SL_IDLE, SL_ADDR, SL_ACK_ADDR, SL_WRITE, SL_ACK_WR, SL_READ, SL_ACK_RD
   } smc_slv_e;
   typedef enum logic {WD_WATCH, WD_CLEAR} smc_wd_e;
endpackage
`default_nettype wire

// ---- rtl/smc_crc_count.sv ----
// Purpose: back channel crc error counter
// Assumes: crc_err is a one-cycle pulse
// Notes:   saturates at all ones
`timescale 1ns/1ns
`default_nettype none
module smc_crc_count (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // events
   input  wire logic        crc_err,
   input  wire logic        clear,
   // count
   output logic [15:0]      count
);
   logic [15:0] next_count;

   always_comb begin
      next_count = count;
      if (clear) begin
         next_count = 16'h0000;
      end else if (crc_err && count != 16'hffff) begin
         next_count = count + 16'h0001;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 16'h0000;
      end else begin
         count <= next_count;
      end
   end
endmodule // smc_crc_count
`default_nettype wire

// ---- rtl/smc_watchdog.sv ----
// Purpose: i2c bus watchdog with free detect and hung bus clear
// Assumes: scl_in and sda_in are the wire levels
// Notes:   scl_oe pulls scl low during the clear sequence
`timescale 1ns/1ns
`default_nettype none
`include "smc_defs.svh"
module smc_watchdog #(
   parameter int unsigned LONG_CYC  = `SMC_WDOG_LONG_CYC,
   parameter int unsigned SHORT_CYC = `SMC_WDOG_SHORT_CYC
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // bus levels
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   // control
   input  wire logic        wd_disable,
   input  wire logic        speedup,
   // status and drive
   output logic             bus_free,
   output logic             clear_active,
   output logic             scl_oe
);
   localparam logic [26:0] LONG_LIM  = 27'(LONG_CYC - 1);
   localparam logic [26:0] SHORT_LIM = 27'(SHORT_CYC - 1);
   localparam logic [9:0]  HALF_LIM  = 10'(`SMC_CLR_HALF_CYC - 1);
   localparam logic [4:0]  PH_LAST   = 5'(2 * `SMC_CLR_PULSES - 1);

   smc_pkg::smc_wd_e st, next_st;
   logic [26:0] cnt, next_cnt, limit;
   logic [4:0]  phase, next_phase;
   logic [9:0]  half, next_half;
   logic        prev_scl, prev_sda, next_bus_free, next_scl_oe, activity;

   assign clear_active = (st == smc_pkg::WD_CLEAR);

   always_comb begin
      next_st       = st;
      next_cnt      = cnt;
      next_phase    = phase;
      next_half     = half;
      next_bus_free = bus_free;
      next_scl_oe   = scl_oe;
      activity      = (scl_in != prev_scl) || (sda_in != prev_sda);
      limit         = speedup ? SHORT_LIM : LONG_LIM;
      unique case (st)
         smc_pkg::WD_WATCH: begin
            next_scl_oe = 1'b0;
            if (wd_disable || activity) begin
               next_cnt      = 27'h0000000;
               next_bus_free = 1'b0;
            end else if (cnt >= limit) begin
               if (sda_in) begin
                  next_bus_free = 1'b1;
               end else begin
                  next_st     = smc_pkg::WD_CLEAR;
                  next_phase  = 5'h00;
                  next_half   = 10'h000;
                  next_scl_oe = 1'b1;
               end
            end else begin
               next_cnt = cnt + 27'h0000001;
            end
         end
         smc_pkg::WD_CLEAR: begin
            if (wd_disable) begin
               next_st     = smc_pkg::WD_WATCH;
               next_scl_oe = 1'b0;
               next_cnt    = 27'h0000000;
            end else if (half == HALF_LIM) begin
               next_half = 10'h000;
               if (phase == PH_LAST) begin
                  next_st     = smc_pkg::WD_WATCH;
                  next_scl_oe = 1'b0;
                  next_cnt    = 27'h0000000;
               end else begin
                  next_phase  = phase + 5'h01;
                  next_scl_oe = phase[0];
               end
            end else begin
               next_half = half + 10'h001;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st       <= smc_pkg::WD_WATCH;
         cnt      <= 27'h0000000;
         phase    <= 5'h00;
         half     <= 10'h000;
         bus_free <= 1'b0;
         scl_oe   <= 1'b0;
         prev_scl <= 1'b1;
         prev_sda <= 1'b1;
      end else begin
         st       <= next_st;
         cnt      <= next_cnt;
         phase    <= next_phase;
         half     <= next_half;
         bus_free <= next_bus_free;
         scl_oe   <= next_scl_oe;
         prev_scl <= scl_in;
         prev_sda <= sda_in;
      end
   end
endmodule // smc_watchdog
`default_nettype wire

// ---- rtl/smc_top.sv ----
// Purpose: mode and i2c slave control registers of a video serializer
// Assumes: pins synchronous to mclk; open-drain i2c pins
// Notes:   registers reached over the i2c slave or the remote channel
//
// Summary of operation
// - Crc clear bit at one holds crc counters at zero; not self-clearing.
// - Legacy source bit zero takes mode from strap, one from register.
// - Legacy bit one enables old-deserializer compatibility; default off.
// - Frequency source bit zero takes range from strap, one from register.
// - Low-frequency bit one selects 5 to under 15 MHz; zero 15-85 MHz.
// - Two-bit delay field gives sda output delay 240/280/320/360 ns.
// - Write-block bit does not affect remote access to local-side slaves.
// - Watchdog expires after about 1 s, or about 50 ms with speedup.
// - Watchdog disable bit one turns the bus watchdog off.
// - Sda high and quiet for the watchdog period means bus free.
// - Sda low and quiet until expiry makes nine scl clear pulses.
// - Crc error count reads as low and high bytes, both reset zero.
`timescale 1ns/1ns
`default_nettype none
`include "smc_defs.svh"
module smc_top #(
   parameter int unsigned WDOG_LONG_CYC  = `SMC_WDOG_LONG_CYC,
   parameter int unsigned WDOG_SHORT_CYC = `SMC_WDOG_SHORT_CYC,
   parameter logic [6:0]  DEV_ADDR       = `SMC_DEV_ADDR
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset_n,
   // i2c pins
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   // mode strap decode
   input  wire logic        strap_legacy_mode,
   input  wire logic        strap_low_freq,
   // remote control channel
   input  wire logic        remote_wr_valid,
   output logic             remote_wr_ready,
   input  wire logic        remote_wr_local,
   input  wire logic [7:0]  remote_wr_addr,
   input  wire logic [7:0]  remote_wr_data,
   output logic             remote_wr_refused,
   output logic             slave_fwd_valid,
   output logic [7:0]       slave_fwd_addr,
   output logic [7:0]       slave_fwd_data,
   // back channel
   input  wire logic        crc_err,
   // configuration out
   output logic             legacy_compat_mode,
   output logic             low_freq_range_select,
   output logic             failsafe_low,
   output logic [15:0]      crc_count,
   output logic             bus_free,
   output logic             bus_clear_active
);
   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   logic rst_meta, rst_n;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [5:0] sda_dly_cyc(input logic [1:0] code);
      int ns;
      ns = `SMC_SDA_DLY_BASE_NS + `SMC_SDA_DLY_STEP_NS * int'(code);
      return 6'((ns + `SMC_CLK_PERIOD_NS - 1) / `SMC_CLK_PERIOD_NS);
   endfunction

   function automatic logic [7:0] masked_write(input logic [7:0] cur,
         input logic [7:0] data, input logic [7:0] wmask);
      return (cur & ~wmask) | (data & wmask);
   endfunction

   // ---------------------------------------------------------------
   // configuration registers
   // ---------------------------------------------------------------
   logic [7:0] mode_config, i2c_slave_control;
   logic [7:0] next_mode_config, next_i2c_slave_control;
   logic       i2c_wr_en, rem_take, wr_en;
   logic [7:0] i2c_wr_addr, i2c_wr_data, wr_addr, wr_data;
   logic       next_refused, next_fwd_valid;
   logic [7:0] next_fwd_addr, next_fwd_data;

   assign remote_wr_ready = !i2c_wr_en;
   assign rem_take = remote_wr_valid && remote_wr_ready && remote_wr_local
                     && !i2c_slave_control[`SMC_B_WBLK];
   assign wr_en    = i2c_wr_en || rem_take;
   assign wr_addr  = i2c_wr_en ? i2c_wr_addr : remote_wr_addr;
   assign wr_data  = i2c_wr_en ? i2c_wr_data : remote_wr_data;

   always_comb begin
      next_mode_config       = mode_config;
      next_i2c_slave_control = i2c_slave_control;
      if (wr_en && wr_addr == `SMC_OFF_MODE) begin
         next_mode_config = masked_write(mode_config, wr_data,
                                         `SMC_MODE_WMASK);
      end
      if (wr_en && wr_addr == `SMC_OFF_I2C) begin
         next_i2c_slave_control = masked_write(i2c_slave_control, wr_data,
                                               `SMC_I2C_WMASK);
      end
      next_refused   = remote_wr_valid && remote_wr_ready && remote_wr_local
                       && i2c_slave_control[`SMC_B_WBLK];
      next_fwd_valid = remote_wr_valid && remote_wr_ready
                       && !remote_wr_local;
      next_fwd_addr  = next_fwd_valid ? remote_wr_addr : slave_fwd_addr;
      next_fwd_data  = next_fwd_valid ? remote_wr_data : slave_fwd_data;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mode_config       <= `SMC_MODE_RST;
         i2c_slave_control <= `SMC_I2C_RST;
         remote_wr_refused <= 1'b0;
         slave_fwd_valid   <= 1'b0;
         slave_fwd_addr    <= 8'h00;
         slave_fwd_data    <= 8'h00;
      end else begin
         mode_config       <= next_mode_config;
         i2c_slave_control <= next_i2c_slave_control;
         remote_wr_refused <= next_refused;
         slave_fwd_valid   <= next_fwd_valid;
         slave_fwd_addr    <= next_fwd_addr;
         slave_fwd_data    <= next_fwd_data;
      end
   end

   // ---------------------------------------------------------------
   // mode outputs
   // ---------------------------------------------------------------
   logic next_legacy, next_low_freq;

   always_comb begin
      next_legacy   = mode_config[`SMC_B_LEG_SRC] ?
                      mode_config[`SMC_B_LEG] : strap_legacy_mode;
      next_low_freq = mode_config[`SMC_B_LF_SRC] ?
                      mode_config[`SMC_B_LF] : strap_low_freq;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         legacy_compat_mode    <= 1'b0;
         low_freq_range_select <= 1'b0;
      end else begin
         legacy_compat_mode    <= next_legacy;
         low_freq_range_select <= next_low_freq;
      end
   end

   assign failsafe_low = mode_config[`SMC_B_FAILSAFE];

   // ---------------------------------------------------------------
   // counter and watchdog
   // ---------------------------------------------------------------
   smc_crc_count u_crc (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .crc_err (crc_err),
      .clear   (mode_config[`SMC_B_CRC_CLR]),
      .count   (crc_count)
   );

   smc_watchdog #(
      .LONG_CYC  (WDOG_LONG_CYC),
      .SHORT_CYC (WDOG_SHORT_CYC)
   ) u_wdog (
      .mclk         (mclk),
      .rst_n        (rst_n),
      .scl_in       (scl_in),
      .sda_in       (sda_in),
      .wd_disable   (i2c_slave_control[`SMC_B_WDIS]),
      .speedup      (i2c_slave_control[`SMC_B_SPEEDUP]),
      .bus_free     (bus_free),
      .clear_active (bus_clear_active),
      .scl_oe       (scl_oe)
   );

   assign scl_out = 1'b0;
   assign sda_out = 1'b0;

   // ---------------------------------------------------------------
   // i2c slave
   // ---------------------------------------------------------------
   smc_pkg::smc_slv_e st, next_st;
   logic [3:0] cnt, next_cnt;
   logic [7:0] sh, next_sh, ptr, next_ptr, rdata;
   logic [5:0] dly, next_dly;
   logic       rw, next_rw, first, next_first, drive, next_drive;
   logic       nack, next_nack, next_sda_oe, prev_scl, prev_sda;
   logic       scl_rise, scl_fall, start_c, stop_c;

   always_comb begin
      unique case (ptr)
         `SMC_OFF_MODE:   rdata = mode_config;
         `SMC_OFF_I2C:    rdata = i2c_slave_control;
         `SMC_OFF_CRC_LO: rdata = crc_count[7:0];
         `SMC_OFF_CRC_HI: rdata = crc_count[15:8];
         default:         rdata = 8'h00;
      endcase
   end

   always_comb begin
      scl_rise    = scl_in && !prev_scl;
      scl_fall    = !scl_in && prev_scl;
      start_c     = scl_in && prev_scl && prev_sda && !sda_in;
      stop_c      = scl_in && prev_scl && !prev_sda && sda_in;
      next_st     = st;
      next_cnt    = cnt;
      next_sh     = sh;
      next_ptr    = ptr;
      next_rw     = rw;
      next_first  = first;
      next_drive  = drive;
      next_nack   = nack;
      i2c_wr_en   = 1'b0;
      i2c_wr_addr = ptr;
      i2c_wr_data = sh;
      if (start_c) begin
         next_st    = smc_pkg::SL_ADDR;
         next_cnt   = 4'h0;
         next_drive = 1'b0;
      end else if (stop_c) begin
         next_st    = smc_pkg::SL_IDLE;
         next_drive = 1'b0;
      end else begin
         unique case (st)
            smc_pkg::SL_IDLE: ;
            smc_pkg::SL_ADDR, smc_pkg::SL_WRITE: begin
               if (scl_rise) begin
                  next_sh  = {sh[6:0], sda_in};
                  next_cnt = cnt + 4'h1;
               end else if (scl_fall && cnt == 4'h8) begin
                  next_drive = 1'b1;
                  if (st == smc_pkg::SL_WRITE) begin
                     next_st = smc_pkg::SL_ACK_WR;
                     if (first) begin
                        next_ptr = sh;
                     end else begin
                        i2c_wr_en = 1'b1;
                        next_ptr  = ptr + 8'h01;
                     end
                  end else if (sh[7:1] == DEV_ADDR) begin
                     next_st = smc_pkg::SL_ACK_ADDR;
                     next_rw = sh[0];
                  end else begin
                     next_st    = smc_pkg::SL_IDLE;
                     next_drive = 1'b0;
                  end
               end
            end
            smc_pkg::SL_ACK_WR: begin
               if (scl_fall) begin
                  next_st    = smc_pkg::SL_WRITE;
                  next_drive = 1'b0;
                  next_cnt   = 4'h0;
                  next_first = 1'b0;
               end
            end
            smc_pkg::SL_ACK_ADDR, smc_pkg::SL_ACK_RD: begin
               if (scl_rise) begin
                  next_nack = sda_in && st == smc_pkg::SL_ACK_RD;
               end else if (scl_fall) begin
                  next_cnt = 4'h0;
                  if (!rw) begin
                     next_st    = smc_pkg::SL_WRITE;
                     next_first = 1'b1;
                     next_drive = 1'b0;
                  end else if (nack) begin
                     next_st    = smc_pkg::SL_IDLE;
                     next_drive = 1'b0;
                  end else begin
                     next_st    = smc_pkg::SL_READ;
                     next_sh    = rdata;
                     next_ptr   = ptr + 8'h01;
                     next_drive = !rdata[7];
                  end
               end
            end
            smc_pkg::SL_READ: begin
               if (scl_rise) begin
                  next_cnt = cnt + 4'h1;
               end else if (scl_fall) begin
                  if (cnt == 4'h8) begin
                     next_st    = smc_pkg::SL_ACK_RD;
                     next_drive = 1'b0;
                     next_nack  = 1'b0;
                  end else begin
                     next_sh    = {sh[6:0], 1'b0};
                     next_drive = !sh[6];
                  end
               end
            end
         endcase
      end
      // sda changes after the programmed delay past scl fall, or is released at once on idle or bus clear
      next_dly    = dly;
      next_sda_oe = sda_oe;
      if (next_st == smc_pkg::SL_IDLE || bus_clear_active) begin
         next_dly    = 6'h00;
         next_sda_oe = 1'b0;
      end else if (scl_fall) begin
         next_dly = sda_dly_cyc(i2c_slave_control[`SMC_B_DLY_HI:
                                                  `SMC_B_DLY_LO]);
      end else if (dly == 6'h01) begin
         next_dly    = 6'h00;
         next_sda_oe = drive;
      end else if (dly != 6'h00) begin
         next_dly = dly - 6'h01;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st       <= smc_pkg::SL_IDLE;
         cnt      <= 4'h0;
         sh       <= 8'h00;
         ptr      <= 8'h00;
         rw       <= 1'b0;
         first    <= 1'b0;
         drive    <= 1'b0;
         nack     <= 1'b0;
         dly      <= 6'h00;
         sda_oe   <= 1'b0;
         prev_scl <= 1'b1;
         prev_sda <= 1'b1;
      end else begin
         st       <= next_st;
         cnt      <= next_cnt;
         sh       <= next_sh;
         ptr      <= next_ptr;
         rw       <= next_rw;
         first    <= next_first;
         drive    <= next_drive;
         nack     <= next_nack;
         dly      <= next_dly;
         sda_oe   <= next_sda_oe;
         prev_scl <= scl_in;
         prev_sda <= sda_in;
      end
   end
endmodule // smc_top
`default_nettype wire

// ---- testbench/smc_top_sva.sv ----
// Purpose: port checker for smc_top
// Assumes: pins synchronous to mclk
// Notes:   bound to every smc_top
`timescale 1ns/1ns
`default_nettype none
module smc_chk (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset_n,
   // pins
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   input  wire logic        scl_oe,
   input  wire logic        sda_oe,
   // remote channel
   input  wire logic        remote_wr_valid,
   input  wire logic        remote_wr_ready,
   input  wire logic        remote_wr_local,
   input  wire logic [7:0]  remote_wr_data,
   input  wire logic        remote_wr_refused,
   input  wire logic        slave_fwd_valid,
   input  wire logic [7:0]  slave_fwd_data,
   // status
   input  wire logic        crc_err,
   input  wire logic [15:0] crc_count,
   input  wire logic        bus_free,
   input  wire logic        bus_clear_active
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   logic take;
   assign take = remote_wr_valid && remote_wr_ready;
   chk_refuse_cause: assert property (remote_wr_refused |->
      $past(take && remote_wr_local)) else $error("refusal without write");
   chk_one_answer: assert property (!(remote_wr_refused &&
      slave_fwd_valid)) else $error("refused and forwarded together");
   chk_fwd_take: assert property (take && !remote_wr_local |=>
      slave_fwd_valid && slave_fwd_data == $past(remote_wr_data))
      else $error("slave write not forwarded");
   chk_fwd_cause: assert property (slave_fwd_valid |->
      $past(take && !remote_wr_local)) else $error("forward without write");
   chk_crc_step: assert property ($changed(crc_count) |->
      crc_count == 16'h0 ||
      (crc_count == $past(crc_count) + 16'h1 && $past(crc_err)))
      else $error("crc count moved wrongly");
   chk_clear_quiet: assert property (bus_clear_active |-> !sda_oe)
      else $error("sda driven during bus clear");
   chk_scl_clear: assert property (scl_oe |-> bus_clear_active ||
      $past(bus_clear_active)) else $error("scl pulled outside clear");
   chk_clear_hold: assert property ($rose(bus_clear_active) |->
      bus_clear_active [*8]) else $error("bus clear too short");
   chk_free_sda: assert property ($rose(bus_free) |-> sda_in &&
      $past(sda_in) && $stable(scl_in)) else $error("free with sda low");
endmodule // smc_chk
bind smc_top smc_chk u_chk (.mclk(mclk), .reset_n(reset_n),
   .scl_in(scl_in), .sda_in(sda_in), .scl_oe(scl_oe), .sda_oe(sda_oe),
   .remote_wr_valid(remote_wr_valid), .remote_wr_ready(remote_wr_ready),
   .remote_wr_local(remote_wr_local), .remote_wr_data(remote_wr_data),
   .remote_wr_refused(remote_wr_refused), .slave_fwd_valid(slave_fwd_valid),
   .slave_fwd_data(slave_fwd_data), .crc_err(crc_err), .crc_count(crc_count),
   .bus_free(bus_free), .bus_clear_active(bus_clear_active));
`default_nettype wire

// ---- testbench/smc_host.sv ----
// Purpose: i2c host side of the bus with open-drain wires
// Assumes: pull-ups on scl and sda
// Notes:   host can only hold scl or sda low or release them
`timescale 1ns/1ns
`default_nettype none
module smc_host (
   // drives
   input  wire logic hold_sda_low,
   input  wire logic hold_scl_low,
   input  wire logic scl_oe,
   input  wire logic sda_oe,
   // wire levels
   output logic      scl,
   output logic      sda
);
   assign scl = !(scl_oe || hold_scl_low);
   assign sda = !(sda_oe || hold_sda_low);
endmodule // smc_host
`default_nettype wire

// ---- testbench/testbench.sv ----
// Purpose: self-checking bench for smc_top
// Assumes: watchdog counts shortened to 200 and 50 cycles
// Notes:   registers written over the remote channel
`timescale 1ns/1ns
`default_nettype none
module testbench;
   localparam int LONG = 200;
   localparam int SHORT = 50;
   logic mclk = 1'b0, reset_n = 1'b0, hold_low = 1'b0, crc_err = 1'b0;
   logic s_leg = 1'b1, s_lf = 1'b1, wv = 1'b0, wl = 1'b0, prev, hscl = 1'b0;
   logic [7:0] wa = 8'h00, wd = 8'h00, fa, fdat;
   logic scl, sda, scl_oe, sda_oe, rdy, refused, fwd, leg, lf, fsl, bfree;
   logic bclr;
   logic [15:0] cnt;
   int bad_count = 0, num_checks = 0, cyc, n, tick = 0;
   smc_host u_host (.hold_sda_low(hold_low), .scl_oe(scl_oe),
      .hold_scl_low(hscl), .sda_oe(sda_oe), .scl(scl), .sda(sda));
   smc_top #(.WDOG_LONG_CYC(LONG), .WDOG_SHORT_CYC(SHORT)) DUT (
      .mclk(mclk), .reset_n(reset_n), .scl_in(scl), .scl_out(),
      .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
      .strap_legacy_mode(s_leg), .strap_low_freq(s_lf),
      .remote_wr_valid(wv), .remote_wr_ready(rdy), .remote_wr_local(wl),
      .remote_wr_addr(wa), .remote_wr_data(wd), .remote_wr_refused(refused),
      .slave_fwd_valid(fwd), .slave_fwd_addr(fa), .slave_fwd_data(fdat),
      .crc_err(crc_err), .legacy_compat_mode(leg), .low_freq_range_select(lf),
      .failsafe_low(fsl), .crc_count(cnt), .bus_free(bfree),
      .bus_clear_active(bclr));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic loc, input logic [7:0] a, d);
      @(negedge mclk);
      wv = 1'b1;
      wl = loc;
      wa = a;
      wd = d;
      while (rdy !== 1'b1) @(negedge mclk);
      @(negedge mclk);
      wv = 1'b0;
   endtask
   task automatic pulse(input int k);
      repeat (k) begin
         @(negedge mclk) crc_err = 1'b1;
         @(negedge mclk) crc_err = 1'b0;
      end
   endtask
   task automatic t_mode();
      chk({leg, lf}, 2'b11);
      wr(1'b1, 8'h04, 8'h8a);
      @(negedge mclk) chk({leg, lf}, 2'b00);
      s_leg = 1'b0;
      s_lf = 1'b0;
      wr(1'b1, 8'h04, 8'h8d);
      @(negedge mclk) chk({leg, lf}, 2'b10);
      wr(1'b1, 8'h04, 8'h0f);
      @(negedge mclk) chk({leg, lf, fsl}, 3'b110);
   endtask
   task automatic t_crc();
      pulse(3);
      chk(cnt, 16'h0003);
      wr(1'b1, 8'h04, 8'h20);
      pulse(2);
      chk(cnt, 16'h0000);
      wr(1'b1, 8'h04, 8'h00);
      pulse(1);
      chk(cnt, 16'h0001);
   endtask
   task automatic t_wdog();
      repeat (4) @(negedge mclk) hold_low = 1'b1;
      hold_low = 1'b0;
      for (cyc = 0; bfree !== 1'b1 && cyc < 2000; cyc++) @(negedge mclk);
      chk(16'(cyc >= LONG && cyc <= LONG + 8), 16'h1);
      wr(1'b1, 8'h05, 8'h02);
      hold_low = 1'b1;
      for (cyc = 0; bclr !== 1'b1 && cyc < 2000; cyc++) @(negedge mclk);
      chk(16'(cyc >= SHORT && cyc <= SHORT + 8), 16'h1);
      prev = scl;
      for (n = 0; bclr === 1'b1 && cyc < 20000; cyc++) begin
         @(negedge mclk);
         if (!prev && scl) n++;
         prev = scl;
      end
      chk(16'(n), 16'h0009);
      hold_low = 1'b0;
      wr(1'b1, 8'h05, 8'h03);
      repeat (LONG + 100) @(negedge mclk);
      chk(bfree, 1'b0);
   endtask
   task automatic t_sda();
      wr(1'b1, 8'h05, 8'h18);
      hold_low = 1'b1;
      for (n = 7; n >= 0; n--) begin
         repeat (50) @(negedge mclk) hscl = 1'b1;
         hold_low = !((8'h74 >> n) & 8'h01);
         repeat (50) @(negedge mclk) hscl = 1'b0;
      end
      @(negedge mclk) hscl = 1'b1;
      hold_low = 1'b0;
      for (cyc = 0; sda_oe !== 1'b1 && cyc < 100; cyc++) @(negedge mclk);
      // 360 ns at 8 ns plus the edge that sees scl fall
      chk(16'(cyc), 16'h002e);
   endtask
   task automatic t_block();
      wr(1'b1, 8'h05, 8'h04);
      wr(1'b1, 8'h04, 8'h0f);
      chk(refused, 1'b1);
      wr(1'b0, 8'h52, 8'ha5);
      chk({fwd, fa, fdat}, 17'h152a5);
      chk({refused, leg, lf}, 3'b000);
   endtask
   initial begin
      forever #4 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      tick++;
      if (tick == 30000) begin
         bad_count++;
         give_verdict();
      end
   end
   initial begin
      repeat (2) @(negedge mclk);
      chk({fsl, leg, lf, cnt}, 19'h40000);
      reset_n = 1'b1;
      repeat (4) @(negedge mclk);
      t_mode();
      t_crc();
      t_wdog();
      t_sda();
      t_block();
      give_verdict();
   end
endmodule // testbench
`default_nettype wire
